// ===== src/ppsw_status_word.sv
/*
  Profile position status word generator: builds the mode and maker
  specific bits of the 16-bit drive status word and the set-point
  handshake. Assumes all inputs are synchronous to i_ref_clk, that
  bits 6..0 come from the drive state machine, and that the word is
  read-only: the network side has no write path into it.
*/
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Bit 15 shows 1 while the load holds the motor at its upper torque limit, else 0.
// - Bit 13 goes to 1 when position deviation exceeds the following error window.
// - Bit 13 returns to 0 only on reset of an excessive deviation or overload alarm.
// - Bit 12 goes to 1 when a start requested by new set point rising is accepted.
// - The master drops new set point after the acknowledge, and bit 12 then clears.
// - Bit 11 is 1 while any limit sensor, operation block, software or mechanism limit acts.
// - With halt at 0, bit 10 stays 0 until positioning completes and the position settles in the window.
// - Bit 10 stays 0 when positioning is interrupted before normal completion.
// - Bit 10 clears when a new operation starts after a completed positioning.
// - With halt at 1, bit 10 is 0 during the deceleration and 1 once velocity demand is zero.
// - Bit 9 goes to 1 once initialization has completed.
// - Bit 7 follows the information condition and clears by itself when the cause goes.
// - A set-point request is ignored under halt, stop input, not operation enabled or no excitation.
// - Halt at 1 stops the running operation by the method of the halt option code.
module ppsw_status_word
  import ppsw_pkg::*;
(
  // Clock and reset
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_rst_b,
  // Control word and drive conditions
  input  wire ppsw_ctrl_t            i_ctrl,
  input  wire logic                  i_stop_input,
  input  wire logic                  i_op_enabled,
  input  wire logic                  i_motor_excited,
  input  wire logic                  i_init_done,
  input  wire logic [HALT_OPT_W-1:0] i_halt_option,
  // Drive state machine bits 6..0
  input  wire logic [DSM_W-1:0]      i_dsm_bits,
  // Feedback from motion and limits
  input  wire ppsw_motion_t          i_motion,
  input  wire ppsw_limits_t          i_limits,
  input  wire logic                  i_torque_at_limit,
  input  wire logic [POS_W-1:0]      i_follow_window,
  input  wire logic [POS_W-1:0]      i_position_window,
  input  wire logic                  i_info_active,
  // Alarm reset event
  input  wire logic                  i_alarm_reset,
  input  wire logic [7:0]            i_alarm_code,
  // Status word and commands to the profile generator
  output logic [SW_W-1:0]            o_drive_status_word,
  output logic                       o_start_accept,
  output logic                       o_halt_stop,
  output logic [HALT_OPT_W-1:0]      o_halt_method
);

  function automatic logic [POS_W-1:0] abs_diff(input logic [POS_W-1:0] a, input logic [POS_W-1:0] b);
    logic [POS_W-1:0] d;
    d = a - b;
    abs_diff = d[POS_W-1] ? (~d + 1'b1) : d;
  endfunction

  ppsw_state_t          state_r, state_nxt;
  logic                 nsp_prev_r, nsp_prev_nxt;
  logic                 sp_ack_r, sp_ack_nxt;
  logic                 follow_r, follow_nxt;
  logic                 tgt_r, tgt_nxt;
  logic                 remote_r, remote_nxt;
  logic                 warn_r, warn_nxt;
  logic                 tlr_r, tlr_nxt;
  logic                 limit_r, limit_nxt;
  logic [DSM_W-1:0]     dsm_r, dsm_nxt;
  logic                 halt_stop_r, halt_stop_nxt;
  logic [HALT_OPT_W-1:0] halt_opt_r, halt_opt_nxt;

  logic             start_blocked;
  logic             start_ok;
  logic [POS_W-1:0] deviation;
  logic             in_window;
  logic             follow_clr;
  logic             running;

  // Set-point acceptance and handshake
  always_comb begin
    start_blocked = i_ctrl.halt | i_stop_input | ~i_op_enabled | ~i_motor_excited;
    start_ok      = i_ctrl.new_set_point & ~nsp_prev_r & ~start_blocked;
    nsp_prev_nxt  = i_ctrl.new_set_point;
    sp_ack_nxt    = sp_ack_r;
    if (start_ok) begin
      sp_ack_nxt = 1'b1;
    end else if (!i_ctrl.new_set_point) begin
      sp_ack_nxt = 1'b0;
    end
  end

  // Positioning progress and target reached
  always_comb begin
    deviation = abs_diff(i_motion.command_pos, i_motion.actual_pos);
    in_window = (deviation <= i_position_window);
    running   = (state_r == PP_MOVING) || (state_r == PP_SETTLE);
    state_nxt = state_r;
    tgt_nxt   = tgt_r;
    if (start_ok) begin
      state_nxt = PP_MOVING;
      tgt_nxt   = 1'b0;
    end else if (i_ctrl.halt && state_r != PP_HALTED) begin
      state_nxt = i_motion.velocity_zero ? PP_HALTED : PP_HALTING;
      tgt_nxt   = i_motion.velocity_zero;
    end else begin
      case (state_r)
        PP_IDLE: begin
          tgt_nxt = 1'b0;
        end
        PP_MOVING: begin
          if (i_motion.interrupted) begin
            state_nxt = PP_IDLE;
            tgt_nxt   = 1'b0;
          end else if (i_motion.profile_done) begin
            state_nxt = PP_SETTLE;
          end
        end
        PP_SETTLE: begin
          if (i_motion.interrupted) begin
            state_nxt = PP_IDLE;
            tgt_nxt   = 1'b0;
          end else if (in_window) begin
            state_nxt = PP_DONE;
            tgt_nxt   = 1'b1;
          end
        end
        PP_DONE: begin
          tgt_nxt = 1'b1;
        end
        PP_HALTING: begin
          state_nxt = PP_IDLE;
          tgt_nxt   = 1'b0;
        end
        PP_HALTED: begin
          if (!i_ctrl.halt) begin
            state_nxt = PP_IDLE;
          end
        end
        default: begin
          state_nxt = PP_IDLE;
          tgt_nxt   = 1'b0;
        end
      endcase
    end
  end

  // Halt request to the profile generator
  always_comb begin
    halt_stop_nxt = i_ctrl.halt & (running | (state_r == PP_HALTING));
    halt_opt_nxt  = i_ctrl.halt ? halt_opt_r : i_halt_option;
  end

  // Flag bits
  always_comb begin
    follow_clr = i_alarm_reset &&
                 (i_alarm_code == ALM_EXCESS_DEV || i_alarm_code == ALM_OVERLOAD);
    follow_nxt = follow_r;
    if (deviation > i_follow_window) begin
      follow_nxt = 1'b1;
    end else if (follow_clr) begin
      follow_nxt = 1'b0;
    end
    tlr_nxt    = i_torque_at_limit;
    limit_nxt  = |i_limits;
    remote_nxt = remote_r | i_init_done;
    warn_nxt   = i_info_active;
    dsm_nxt    = i_dsm_bits;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r     <= PP_IDLE;
      nsp_prev_r  <= 1'b0;
      sp_ack_r    <= 1'b0;
      follow_r    <= 1'b0;
      tgt_r       <= 1'b0;
      remote_r    <= 1'b0;
      warn_r      <= 1'b0;
      tlr_r       <= 1'b0;
      limit_r     <= 1'b0;
      dsm_r       <= '0;
      halt_stop_r <= 1'b0;
      halt_opt_r  <= HALT_OPT_RESET;
    end else begin
      state_r     <= state_nxt;
      nsp_prev_r  <= nsp_prev_nxt;
      sp_ack_r    <= sp_ack_nxt;
      follow_r    <= follow_nxt;
      tgt_r       <= tgt_nxt;
      remote_r    <= remote_nxt;
      warn_r      <= warn_nxt;
      tlr_r       <= tlr_nxt;
      limit_r     <= limit_nxt;
      dsm_r       <= dsm_nxt;
      halt_stop_r <= halt_stop_nxt;
      halt_opt_r  <= halt_opt_nxt;
    end
  end

  // Status word assembly; no write path exists
  always_comb begin
    o_drive_status_word                = SW_RESET;
    o_drive_status_word[BIT_TLR]       = tlr_r;
    o_drive_status_word[BIT_RSV14]     = 1'b0;
    o_drive_status_word[BIT_FOLLOW]    = follow_r;
    o_drive_status_word[BIT_SP_ACK]    = sp_ack_r;
    o_drive_status_word[BIT_INT_LIMIT] = limit_r;
    o_drive_status_word[BIT_TGT_REACH] = tgt_r;
    o_drive_status_word[BIT_REMOTE]    = remote_r;
    o_drive_status_word[BIT_RSV8]      = 1'b0;
    o_drive_status_word[BIT_WARNING]   = warn_r;
    o_drive_status_word[DSM_W-1:0]     = dsm_r;
  end

  assign o_start_accept = start_ok;
  assign o_halt_stop    = halt_stop_r;
  assign o_halt_method  = halt_opt_r;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  a_tlr_follows: assert property (i_torque_at_limit |=> o_drive_status_word[BIT_TLR])
    else $error("torque limit bit not set");
  a_follow_sets: assert property ((deviation > i_follow_window) |=> o_drive_status_word[BIT_FOLLOW])
    else $error("following error not set");
  a_follow_holds: assert property ($fell(o_drive_status_word[BIT_FOLLOW]) |-> $past(follow_clr))
    else $error("following error cleared without alarm reset");
  a_ack_sets: assert property (o_start_accept |=> o_drive_status_word[BIT_SP_ACK])
    else $error("set point acknowledge missing");
  a_ack_clears: assert property (!i_ctrl.new_set_point |=> !o_drive_status_word[BIT_SP_ACK])
    else $error("set point acknowledge not cleared");
  a_limit_bit: assert property (|i_limits |=> o_drive_status_word[BIT_INT_LIMIT])
    else $error("internal limit bit not set");
  a_start_clears: assert property (o_start_accept |=> !o_drive_status_word[BIT_TGT_REACH] ##0 state_r == PP_MOVING)
    else $error("target reached not cleared on start");
  a_blocked_start: assert property (start_blocked |-> !o_start_accept)
    else $error("blocked set point accepted");
  a_interrupt_tgt: assert property ((running && i_motion.interrupted && !start_ok && !i_ctrl.halt)
                                   |=> !o_drive_status_word[BIT_TGT_REACH])
    else $error("target reached after interruption");
  a_remote_sticks: assert property (o_drive_status_word[BIT_REMOTE] |=> o_drive_status_word[BIT_REMOTE])
    else $error("remote bit dropped");
  a_reserved_zero: assert property (!o_drive_status_word[BIT_RSV14] && !o_drive_status_word[BIT_RSV8])
    else $error("reserved status bit set");

endmodule

`default_nettype wire

// ===== pkg/ppsw_pkg.sv
/*
  Package for the profile position status word block: status word bit
  positions, alarm codes, state codes and the grouped input carriers.
  Assumes a single 10 MHz control clock in the drive.
*/
package ppsw_pkg;

  // Status word layout
  localparam int unsigned SW_W          = 16;
  localparam int unsigned BIT_TLR       = 15;
  localparam int unsigned BIT_RSV14     = 14;
  localparam int unsigned BIT_FOLLOW    = 13;
  localparam int unsigned BIT_SP_ACK    = 12;
  localparam int unsigned BIT_INT_LIMIT = 11;
  localparam int unsigned BIT_TGT_REACH = 10;
  localparam int unsigned BIT_REMOTE    = 9;
  localparam int unsigned BIT_RSV8      = 8;
  localparam int unsigned BIT_WARNING   = 7;
  localparam int unsigned DSM_W         = 7;
  localparam logic [SW_W-1:0] SW_RESET  = 16'h0000;

  // Position data
  localparam int unsigned POS_W = 32;

  // Alarm codes that clear the following error flag
  localparam logic [7:0] ALM_EXCESS_DEV = 8'h10;
  localparam logic [7:0] ALM_OVERLOAD   = 8'h30;

  // Halt option code width
  localparam int unsigned HALT_OPT_W = 16;
  localparam logic [HALT_OPT_W-1:0] HALT_OPT_RESET = 16'h0000;

  typedef enum logic [2:0] {
    PP_IDLE    = 3'b000,
    PP_MOVING  = 3'b001,
    PP_SETTLE  = 3'b010,
    PP_DONE    = 3'b011,
    PP_HALTING = 3'b100,
    PP_HALTED  = 3'b101
  } ppsw_state_t;

  // Control word bits that this block consumes
  typedef struct packed {
    logic halt;
    logic new_set_point;
  } ppsw_ctrl_t;

  // Internal limit sources
  typedef struct packed {
    logic forward_limit_sensor;
    logic reverse_limit_sensor;
    logic forward_operation_block;
    logic reverse_operation_block;
    logic software_limit;
    logic mechanism_limit;
  } ppsw_limits_t;

  // Motion profile feedback
  typedef struct packed {
    logic             profile_done;
    logic             interrupted;
    logic             velocity_zero;
    logic [POS_W-1:0] command_pos;
    logic [POS_W-1:0] actual_pos;
  } ppsw_motion_t;

endpackage

// ===== verification/ppsw_master.sv
/*
  Network master model: drives the set-point request and reads the word.
  Assumes the status word is sampled on i_ref_clk rising edges.
*/
`timescale 1ns/10ps
`default_nettype none
module ppsw_master
  import ppsw_pkg::*;
(
  // Clock and reset
  input  wire logic            i_ref_clk,
  input  wire logic            i_rst_b,
  // Status word in, request and push completion out
  input  wire logic [SW_W-1:0] i_word,
  output var  logic            o_new_set_point,
  output logic                 o_push_done
);
  initial o_new_set_point = 1'b0;
  // Push completion seen by the master
  assign o_push_done = i_word[BIT_TLR];

  // Raise, wait bounded for acknowledge, then drop
  task automatic request(output logic got);
    int n;
    got = 1'b0;
    @(posedge i_ref_clk) o_new_set_point <= 1'b1;
    for (n = 0; n < 5 && !got; n++) begin
      @(posedge i_ref_clk);
      got = i_word[BIT_SP_ACK];
    end
    o_new_set_point <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
  endtask
endmodule
`default_nettype wire

// ===== verification/profile_position_status_word_bench.sv
/*
  Bench for the status word block: reference model of the level bits and
  handshake checked every cycle, plus target reached and halt scenarios.
  Assumes a master model on the set-point request.
*/
`timescale 1ns/10ps
`default_nettype none
module profile_position_status_word_bench;
  import ppsw_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, halt = 1'b0, stop = 1'b0, op = 1'b0, exc = 1'b0;
  logic init = 1'b0, torque = 1'b0, info = 1'b0, arst = 1'b0, got, nsp, acc, p_nsp;
  logic [HALT_OPT_W-1:0] hopt = '0, hmeth;
  logic [DSM_W-1:0]      dsm = '0;
  logic [POS_W-1:0]      fwin = '0, pwin = '0;
  logic [7:0]            code = '0;
  logic [SW_W-1:0]       dw, ew;
  ppsw_motion_t          mot = '0;
  ppsw_limits_t          lim = '0;
  logic                  hstop, sacc, pdone;
  int err_count = 0, total_checks = 0, cyc = 0, i;
  logic [31:0] seed = 32'h00015456, r;

  always #50 clk = ~clk;

  ppsw_status_word dut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_ctrl({halt, nsp}),
    .i_stop_input(stop), .i_op_enabled(op), .i_motor_excited(exc), .i_init_done(init),
    .i_halt_option(hopt), .i_dsm_bits(dsm), .i_motion(mot), .i_limits(lim),
    .i_torque_at_limit(torque), .i_follow_window(fwin), .i_position_window(pwin),
    .i_info_active(info), .i_alarm_reset(arst), .i_alarm_code(code),
    .o_drive_status_word(dw), .o_start_accept(sacc), .o_halt_stop(hstop), .o_halt_method(hmeth));
  ppsw_master m (.i_ref_clk(clk), .i_rst_b(rst_b), .i_word(dw), .o_new_set_point(nsp), .o_push_done(pdone));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic longint absd(logic [POS_W-1:0] a, logic [POS_W-1:0] b);
    longint d;
    d = longint'($signed(a)) - longint'($signed(b));
    return d < 0 ? -d : d;
  endfunction

  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (err_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic tgt(logic e, int n);
    repeat (n) @(posedge clk);
    @(negedge clk) chk("target_reached", dw[BIT_TGT_REACH], e);
  endtask

  // Reference model, bit 10 left to the scenarios
  assign acc = nsp & !p_nsp & !halt & !stop & op & exc;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ew    <= '0;
      p_nsp <= 1'b0;
    end else begin
      ew[15]  <= torque;
      ew[11]  <= |lim;
      ew[9]   <= ew[9] | init;
      ew[7]   <= info;
      ew[6:0] <= dsm;
      ew[13]  <= (absd(mot.command_pos, mot.actual_pos) > longint'(fwin)) ? 1'b1 :
                 (arst && (code == ALM_EXCESS_DEV || code == ALM_OVERLOAD)) ? 1'b0 : ew[13];
      ew[12]  <= acc ? 1'b1 : (nsp ? ew[12] : 1'b0);
      p_nsp   <= nsp;
    end
  end
  always @(negedge clk) begin
    chk("status_word", dw & 16'hfbff, ew);
    chk("start_accept", sacc, acc);
    chk("push_done", pdone, ew[BIT_TLR]);
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      give_verdict();
    end
  end

  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk) init <= 1'b1;
    op  <= 1'b1;
    exc <= 1'b1;
    @(posedge clk) init <= 1'b0;
    for (i = 0; i < 300; i++) begin
      @(posedge clk);
      r = rnd();
      torque <= r[0];
      lim    <= r[6:1];
      info   <= r[7];
      dsm    <= r[14:8];
      arst   <= r[15];
      code   <= r[17:16] == 2'h0 ? ALM_EXCESS_DEV : r[17:16] == 2'h1 ? ALM_OVERLOAD : r[25:18];
      mot.command_pos <= {28'h0, r[29:26]};
      mot.actual_pos  <= {28'h0, r[3:0]};
      fwin <= {30'h0, r[31:30]};
    end
    @(posedge clk) mot <= '0;
    code <= ALM_OVERLOAD;
    arst <= 1'b1;
    pwin <= 32'h2;
    hopt <= 16'h0002;
    @(posedge clk) arst <= 1'b0;
    m.request(got);
    chk("accepted", got, 1'b1);
    tgt(1'b0, 0);
    @(posedge clk) mot.actual_pos <= 32'h2;
    mot.profile_done <= 1'b1;
    @(posedge clk) mot.profile_done <= 1'b0;
    tgt(1'b1, 3);
    m.request(got);
    tgt(1'b0, 0);
    @(posedge clk) mot.interrupted <= 1'b1;
    @(posedge clk) mot.interrupted <= 1'b0;
    // A late completion must not revive the interrupted move
    @(posedge clk) mot.profile_done <= 1'b1;
    @(posedge clk) mot.profile_done <= 1'b0;
    tgt(1'b0, 4);
    m.request(got);
    @(posedge clk) halt <= 1'b1;
    @(posedge clk) hopt <= 16'h0001;
    tgt(1'b0, 1);
    chk("halt_stop", hstop, 1'b1);
    chk("halt_method", hmeth, 16'h0002);
    @(posedge clk) mot.velocity_zero <= 1'b1;
    tgt(1'b1, 2);
    for (i = 0; i < 4; i++) begin
      @(posedge clk) halt <= (i == 0);
      stop <= (i == 1);
      op   <= (i != 2);
      exc  <= (i != 3);
      m.request(got);
      chk("blocked", got, 1'b0);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
